// ### include/sap_pkg.sv
`default_nettype none
package sap_pkg;
  // Frame: start bit, single-ended flag, three channel bits
  localparam int CFG_BITS = 5;
  localparam int RES_BITS = 13;
  localparam logic [12:0] CODE_MAX = 13'h0FFF;
  localparam logic [12:0] CODE_MIN = 13'h1000;
  localparam logic [12:0] CODE_ZERO = 13'h0000;
  localparam logic [15:0] DIFF_MAX = 16'h0FFF;
  localparam logic [15:0] DIFF_MIN = 16'hF000;
  // Falling edges of acquisition before the hold edge
  localparam logic [3:0] ACQ_FALLS = 4'h1;
  // First serial period in which the host samples result bits
  localparam logic [4:0] RES_FIRST_PER = 5'h06;
  localparam logic [4:0] FRAME_PERIODS = 5'h13;
  localparam int MCLK_PERIOD_NS = 25;
  localparam int SCLK_PERIOD_NS = 400;
  localparam int SCLK_MIN_HZ = 105000;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);
  localparam int FIFO_DEPTH = 16;
  localparam int RES_WORD = 16;
endpackage
`default_nettype wire

// ### include/sap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sap_if;
  logic select_standby_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;
  // Shared output line idles high when nobody drives it
  assign dout_line = dout_oe ? dout : 1'b1;
  modport dev (input select_standby_n, input sclk, input din, output dout, output dout_oe);
  modport host (output select_standby_n, output sclk, output din, input dout_line);
endinterface
`default_nettype wire

// ### rtl/sap_dev.sv
// Contract
// - Select falling edge opens a transaction
// - Select high aborts conversion, enters standby
// - Host raises select between conversions
// - Host shifts channel configuration on serial input
// - Serial input captured on clock rising edge
// - Serial output changes only on falling edges
// - Host serial clock drives conversion and shifting
// - Acquisition lasts one and a half periods
// - Thirteen result bits over thirteen periods
// - Code saturates beyond reference minus one step
// - Step is twice reference over 8192
// - Bipolar output spans all 8192 codes
// - Single-ended bipolar needs pseudo-differential setup
// - Unipolar use gives twelve-bit equivalent range
// - Two's complement, 0x1000 to 0x0FFF
// - Sign bit shifted out first
// - Serial clock kept at 105 kHz minimum
`timescale 1ns/1ps
`default_nettype none
module sap_dev
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  sap_if.dev lnk,
  input wire logic [15:0] i_analog_diff,
  input wire logic i_unipolar,
  output logic [2:0] o_channel_sel,
  output logic o_single_ended,
  output logic o_sampling,
  output logic o_standby
);
  typedef enum logic [2:0] {ST_STANDBY, ST_CONFIG, ST_ACQ, ST_CONV, ST_DONE} sap_dstate_type;

  localparam logic [15:0] DIFF_MAX_L = sap_pkg::DIFF_MAX;
  localparam logic [15:0] DIFF_MIN_L = sap_pkg::DIFF_MIN;
  localparam logic [3:0] CFG_LAST = 4'(sap_pkg::CFG_BITS - 1);
  localparam logic [3:0] RES_LAST = 4'(sap_pkg::RES_BITS - 1);

  // i_analog_diff is the selected pair's difference in steps of 2*Vref/8192
  // Saturation first, then the unipolar clamp
  function automatic logic [12:0] sap_sat(input logic [15:0] d, input logic unip);
    logic [12:0] r;
    r = d[12:0];
    if ($signed(d) > $signed(DIFF_MAX_L))
      r = sap_pkg::CODE_MAX;
    else if ($signed(d) < $signed(DIFF_MIN_L))
      r = sap_pkg::CODE_MIN;
    // Unipolar bias keeps only the positive half
    if (unip && r[12])
      r = sap_pkg::CODE_ZERO;
    return r;
  endfunction

  logic cs_s1_ff, cs_s2_ff;
  logic clk_s1_ff, clk_s2_ff, clk_d_ff;
  logic din_s1_ff, din_s2_ff;
  logic clk_rise, clk_fall, sel_low;
  sap_dstate_type state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [3:0] cfg_ff, nxt_cfg;
  logic [12:0] shift_ff, nxt_shift;
  logic dout_ff, nxt_dout;
  logic [12:0] held;

  // Pins cross from the host domain through two flops each
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_d_ff <= 1'b0;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end
    else
    begin
      cs_s1_ff <= lnk.select_standby_n;
      cs_s2_ff <= cs_s1_ff;
      clk_s1_ff <= lnk.sclk;
      clk_s2_ff <= clk_s1_ff;
      clk_d_ff <= clk_s2_ff;
      din_s1_ff <= lnk.din;
      din_s2_ff <= din_s1_ff;
    end
  end

  // Edges are seen three clocks late; the host half period covers that
  assign clk_rise = clk_s2_ff & ~clk_d_ff;
  assign clk_fall = ~clk_s2_ff & clk_d_ff;
  assign sel_low = ~cs_s2_ff;
  // Code is taken at the hold edge, so the input must be steady by then
  assign held = sap_sat(i_analog_diff, i_unipolar);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cfg = cfg_ff;
    nxt_shift = shift_ff;
    nxt_dout = dout_ff;
    if (!sel_low)
    begin
      nxt_state = ST_STANDBY;
      nxt_cnt = 4'h0;
      nxt_dout = 1'b0;
      // Stale result bits never leak into the next frame
      nxt_shift = 13'h0000;
    end
    else
    begin
      unique case (state_ff)
        ST_STANDBY:
        begin
          nxt_state = ST_CONFIG;
          nxt_cnt = 4'h0;
        end
        ST_CONFIG:
        begin
          // Leading zeros before the start bit are ignored
          if (clk_rise && (cnt_ff != 4'h0 || din_s2_ff))
          begin
            if (cnt_ff != 4'h0)
              nxt_cfg = {cfg_ff[2:0], din_s2_ff};
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == CFG_LAST)
            begin
              nxt_state = ST_ACQ;
              nxt_cnt = 4'h0;
            end
          end
        end
        ST_ACQ:
        begin
          // Second fall closes the sample window
          if (clk_fall)
          begin
            if (cnt_ff != sap_pkg::ACQ_FALLS)
              nxt_cnt = cnt_ff + 4'h1;
            else
            begin
              nxt_state = ST_CONV;
              nxt_dout = held[12];
              nxt_shift = {held[11:0], 1'b0};
              nxt_cnt = 4'h1;
            end
          end
        end
        ST_CONV:
        begin
          if (clk_fall)
          begin
            nxt_dout = shift_ff[12];
            nxt_shift = {shift_ff[11:0], 1'b0};
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == RES_LAST)
              nxt_state = ST_DONE;
          end
        end
        ST_DONE:
        begin
          // Frame ends only when select rises
          if (clk_fall)
            nxt_dout = 1'b0;
        end
        // Codes five to seven are illegal; fall back to standby
        default:
        begin
          nxt_state = ST_STANDBY;
        end
      endcase
    end
  end

  // Registers only; all next values come from the block above
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      state_ff <= ST_STANDBY;
      cnt_ff <= 4'h0;
      cfg_ff <= 4'h0;
      shift_ff <= 13'h0000;
      dout_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cfg_ff <= nxt_cfg;
      shift_ff <= nxt_shift;
      dout_ff <= nxt_dout;
    end
  end

  // Released line reads high on the shared wire
  assign lnk.dout = dout_ff;
  assign lnk.dout_oe = sel_low;
  assign o_single_ended = cfg_ff[3];
  assign o_channel_sel = cfg_ff[2:0];
  assign o_sampling = (state_ff == ST_ACQ);
  assign o_standby = (state_ff == ST_STANDBY);
endmodule // sap_dev
`default_nettype wire

// ### rtl/sap_host.sv
`timescale 1ns/1ps
`default_nettype none
module sap_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
  logic full, empty, push, pop;

  assign full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
  assign empty = (wptr_ff == rptr_ff);
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;

  always_comb
  begin
    nxt_wptr = push ? wptr_ff + 1'b1 : wptr_ff;
    nxt_rptr = pop ? rptr_ff + 1'b1 : rptr_ff;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else
    begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
    end
  end

  // Storage needs no reset; empty flag guards reads
  always_ff @(posedge i_mclk)
  begin
    if (push)
      mem_ff[wptr_ff[AW-1:0]] <= i_in_data;
  end

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_ff[rptr_ff[AW-1:0]];
endmodule // sap_fifo

module sap_host
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  sap_if.host lnk,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_single,
  input wire logic [2:0] i_cmd_chan,
  output logic o_res_valid,
  input wire logic i_res_ready,
  output logic [15:0] o_res_data
);
  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_GAP} sap_hstate_type;

  sap_hstate_type state_ff, nxt_state;
  logic [3:0] tmr_ff, nxt_tmr;
  logic [4:0] per_ff, nxt_per;
  logic phase_ff, nxt_phase;
  logic cs_n_ff, nxt_cs_n, sclk_ff, nxt_sclk, din_ff, nxt_din;
  logic [4:0] cfg_ff, nxt_cfg;
  logic [2:0] chan_ff, nxt_chan;
  logic [12:0] res_ff, nxt_res;
  logic push_ff, nxt_push;
  logic do_s1_ff, do_s2_ff;
  logic fifo_in_ready, tmr_end;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      do_s1_ff <= 1'b0;
      do_s2_ff <= 1'b0;
    end
    else
    begin
      do_s1_ff <= lnk.dout_line;
      do_s2_ff <= do_s1_ff;
    end
  end

  assign tmr_end = (tmr_ff == sap_pkg::SCLK_HALF_LAST);
  // A new frame only starts with room for its result
  assign o_cmd_ready = (state_ff == HS_IDLE) && fifo_in_ready;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_tmr = tmr_end ? 4'h0 : tmr_ff + 4'h1;
    nxt_per = per_ff;
    nxt_phase = phase_ff;
    nxt_cs_n = cs_n_ff;
    nxt_sclk = sclk_ff;
    nxt_din = din_ff;
    nxt_cfg = cfg_ff;
    nxt_chan = chan_ff;
    nxt_res = res_ff;
    nxt_push = 1'b0;
    unique case (state_ff)
      HS_IDLE:
      begin
        nxt_tmr = 4'h0;
        if (i_cmd_valid && o_cmd_ready)
        begin
          nxt_state = HS_RUN;
          nxt_cs_n = 1'b0;
          nxt_cfg = {1'b1, i_cmd_single, i_cmd_chan};
          nxt_din = 1'b1;
          nxt_chan = i_cmd_chan;
          nxt_per = 5'h00;
          nxt_phase = 1'b0;
        end
      end
      HS_RUN:
      begin
        if (tmr_end)
        begin
          nxt_phase = ~phase_ff;
          if (!phase_ff)
            nxt_sclk = 1'b1;
          else
          begin
            // Sample just before the fall, after the device's last update
            if (per_ff >= sap_pkg::RES_FIRST_PER)
              nxt_res = {res_ff[11:0], do_s2_ff};
            nxt_sclk = 1'b0;
            nxt_cfg = {cfg_ff[3:0], 1'b0};
            nxt_din = cfg_ff[3];
            nxt_per = per_ff + 5'h01;
            if (per_ff == sap_pkg::FRAME_PERIODS - 5'h01)
            begin
              nxt_state = HS_GAP;
              nxt_cs_n = 1'b1;
              nxt_din = 1'b0;
              nxt_push = 1'b1;
            end
          end
        end
      end
      HS_GAP:
      begin
        if (tmr_end)
          nxt_state = HS_IDLE;
      end
      default:
      begin
        nxt_state = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      state_ff <= HS_IDLE;
      tmr_ff <= 4'h0;
      per_ff <= 5'h00;
      phase_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      din_ff <= 1'b0;
      cfg_ff <= 5'h00;
      chan_ff <= 3'h0;
      res_ff <= 13'h0000;
      push_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      per_ff <= nxt_per;
      phase_ff <= nxt_phase;
      cs_n_ff <= nxt_cs_n;
      sclk_ff <= nxt_sclk;
      din_ff <= nxt_din;
      cfg_ff <= nxt_cfg;
      chan_ff <= nxt_chan;
      res_ff <= nxt_res;
      push_ff <= nxt_push;
    end
  end

  assign lnk.select_standby_n = cs_n_ff;
  assign lnk.sclk = sclk_ff;
  assign lnk.din = din_ff;

  sap_fifo #(.WIDTH(sap_pkg::RES_WORD), .DEPTH(sap_pkg::FIFO_DEPTH)) u_fifo
  (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(push_ff),
    .o_in_ready(fifo_in_ready),
    .i_in_data({chan_ff, res_ff}),
    .o_out_valid(o_res_valid),
    .i_out_ready(i_res_ready),
    .o_out_data(o_res_data)
  );
endmodule // sap_host
`default_nettype wire

// ### sim/sap_props.sv
`timescale 1ns/1ps
`default_nettype none
module sap_props
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic select_standby_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic sc_ff;
  logic [4:0] rises_ff;
  always_ff @(posedge i_mclk)
  begin
    sc_ff <= sclk;
    if (i_sys_rst || select_standby_n)
    begin
      rises_ff <= 5'h00;
    end
    else if (sclk && !sc_ff)
    begin
      rises_ff <= rises_ff + 5'h01;
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  start_bit_a: assert property ($fell(select_standby_n) |-> din)
    else $error("no start bit at frame open");
  drive_on_a: assert property ($fell(select_standby_n) |-> ##[1:6] dout_oe)
    else $error("output not driven after select");
  abort_a: assert property ($rose(select_standby_n) |-> ##[1:6] !dout_oe)
    else $error("output kept after select high");
  released_a: assert property (select_standby_n [*6] |-> !dout_oe)
    else $error("output driven while deselected");
  din_steady_a: assert property ($changed(din) |-> !sclk)
    else $error("serial input moved in high half");
  dout_fall_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk)
    else $error("serial output moved in high half");
  clk_idle_a: assert property (select_standby_n |-> !sclk)
    else $error("serial clock runs outside frame");
  clk_half_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high half wrong");
  frame_len_a: assert property ($rose(select_standby_n) |-> rises_ff == 5'h13)
    else $error("frame period count wrong");
endmodule // sap_props
`default_nettype wire

// ### sim/tb_sar_adc_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_serial_port;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [15:0] diff = 16'h0000;
  logic uni = 1'b0;
  logic cv = 1'b0;
  logic cs = 1'b0;
  logic [2:0] ch = 3'h0;
  logic rr = 1'b0;
  logic rd_en = 1'b0;
  logic cr, rv, samp, stby, sgl, sc_q, sel_q;
  logic [2:0] csel;
  logic [15:0] rdat;
  logic [31:0] seed = 32'h0001421A;
  logic [15:0] exp_a [64];
  logic sg_a [64];
  logic [18:0] dsr, osr;
  logic [15:0] dv [10] = '{16'h0FFF, 16'h1000, 16'hF000, 16'hEFFF, 16'h0001,
    16'hFFFF, 16'h0000, 16'h7FFF, 16'h8000, 16'h0800};
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int wr_i = 0;
  int fr_i = 0;
  int rd_i = 0;
  int rise_n = 0;
  int i;
  sap_if lnk();
  sap_dev i_sap_dev(.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .lnk(lnk), .i_analog_diff(diff),
    .i_unipolar(uni), .o_channel_sel(csel), .o_single_ended(sgl), .o_sampling(samp),
    .o_standby(stby));
  sap_host i_sap_host(.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .lnk(lnk), .i_cmd_valid(cv),
    .o_cmd_ready(cr), .i_cmd_single(cs), .i_cmd_chan(ch), .o_res_valid(rv),
    .i_res_ready(rr), .o_res_data(rdat));
  sap_props i_sap_props(.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .select_standby_n(lnk.select_standby_n), .sclk(lnk.sclk), .din(lnk.din),
    .dout(lnk.dout), .dout_oe(lnk.dout_oe));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Saturating two's complement code, negatives dropped in unipolar use
  function automatic logic [12:0] code(input logic [15:0] d, input logic u);
    int v;
    v = $signed(d);
    if (v > 4095) v = 4095;
    if (v < -4096) v = -4096;
    if (u && v < 0) v = 0;
    return 13'(v);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wt(ref int v, input int n);
    int t;
    t = 0;
    while (v < n && t < 20000)
    begin
      @(posedge i_mclk);
      t++;
    end
    if (v < n)
    begin
      n_fail++;
      $display("mismatch progress exp %0d got %0d", n, v);
    end
    #2;
  endtask
  task cmd(input int k);
    int t;
    t = 0;
    while (cr !== 1'b1 && t < 2000)
    begin
      @(posedge i_mclk);
      #2;
      t++;
    end
    if (cr !== 1'b1)
    begin
      n_fail++;
      $display("mismatch cmd_ready exp 1 got %b", cr);
    end
    seed = xs(seed);
    ch = seed[2:0];
    cs = seed[3];
    uni = (k == 5) | (seed[4] & seed[5]);
    diff = (k < 10) ? dv[k] : seed[31:16];
    exp_a[wr_i] = {ch, code(diff, uni)};
    sg_a[wr_i] = cs;
    wr_i++;
    cv = 1'b1;
    @(posedge i_mclk);
    #2;
    cv = 1'b0;
  endtask
  initial
  begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      $display("mismatch results exp %0d got %0d", wr_i, rd_i);
      end_sim();
    end
    else
    begin
      if (rv === 1'b1 && rr === 1'b1 && rd_i < wr_i)
      begin
        chk("result", exp_a[rd_i], rdat);
        rd_i++;
      end
      #2;
      seed = xs(seed);
      rr = rd_en & seed[7];
    end
  end
  // Wire watch at the falling mclk edge, where the link has settled
  always @(negedge i_mclk)
  begin
    if (!lnk.sclk && sc_q) osr = {osr[17:0], lnk.dout_line};
    if (lnk.select_standby_n) rise_n = 0;
    else if (lnk.sclk && !sc_q)
    begin
      rise_n++;
      dsr = {dsr[17:0], lnk.din};
      chk("standby", 16'h0, 16'(stby));
      if (rise_n == 3) chk("sampling", 16'h0, 16'(samp));
      if (rise_n == 6) chk("sampling", 16'h1, 16'(samp));
    end
    if (lnk.select_standby_n && !sel_q && fr_i < wr_i)
    begin
      chk("din", {11'h001, sg_a[fr_i], exp_a[fr_i][15:13]}, 16'(dsr[18:14]));
      chk("dout", 16'(exp_a[fr_i][12:0]), 16'(osr[12:0]));
      chk("channel", 16'(exp_a[fr_i][15:13]), 16'(csel));
      chk("single", 16'(sg_a[fr_i]), 16'(sgl));
      fr_i++;
    end
    sc_q = lnk.sclk;
    sel_q = lnk.select_standby_n;
  end
  initial
  begin
    repeat (10) @(posedge i_mclk);
    #2;
    i_sys_rst = 1'b0;
    chk("standby", 16'h1, 16'(stby));
    for (i = 0; i < 16; i++) cmd(i);
    wt(fr_i, 16);
    repeat (8) @(posedge i_mclk);
    chk("cmd_ready", 16'h0, 16'(cr));
    chk("standby", 16'h1, 16'(stby));
    rd_en = 1'b1;
    for (i = 16; i < 40; i++) cmd(i);
    wt(rd_i, 40);
    end_sim();
  end
endmodule // tb_sar_adc_serial_port
`default_nettype wire
